// file: pin_mux_pkg.sv
// package for the pin function select block: register map, field layout,
// reset values and the packed carriers shared by the design files.
// assumes an axi4-lite master with 32-bit data on the peripheral clock.
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CS_ROUTE = 8'h00;
  localparam logic [7:0] ADDR_PORT_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PIN_STATUS = 8'h08;

  localparam logic [7:0] CS_ROUTE_RESET = 8'h00;
  localparam logic [7:0] PORT_CTRL_RESET = 8'h00;

  // chip_select_pin_route fields (hi bit, lo bit of each route pair)
  localparam int CS7_ROUTE_HI_POS = 7;
  localparam int CS7_ROUTE_LO_POS = 6;
  localparam int CS6_ROUTE_HI_POS = 5;
  localparam int CS6_ROUTE_LO_POS = 4;
  localparam int CS5_ROUTE_HI_POS = 3;
  localparam int CS5_ROUTE_LO_POS = 2;
  localparam int CS4_ROUTE_HI_POS = 1;
  localparam int CS4_ROUTE_LO_POS = 0;

  // port control fields
  localparam int PORT24_DIR_POS = 0;
  localparam int PORT23_DIR_POS = 1;
  localparam int PORTA7_DIR_POS = 2;

  // route codes
  localparam logic [1:0] ROUTE_A = 2'h0;
  localparam logic [1:0] ROUTE_B = 2'h1;
  localparam logic [1:0] ROUTE_C = 2'h2;
  localparam logic [1:0] ROUTE_D = 2'h3;
  localparam logic [1:0] CKE_INT_OUT = 2'h1;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic timer4_io_b_oe;
    logic timer4_io_b;
    logic serial_clock_ch1_oe;
    logic serial_clock_ch1;
    logic pulse_out_4_oe;
    logic pulse_out_4;
    logic timer3_io_d_oe;
    logic timer3_io_d;
    logic pulse_out_3_oe;
    logic pulse_out_3;
    logic port24_out;
    logic port23_out;
  } port2_src_t;

  typedef struct packed {
    logic clock_out_select;
    logic bus_clock;
    logic bus_release_enable;
    logic bus_request_out_en;
    logic bus_request_out;
    logic high_write_strobe_en;
    logic rw_direction_out_en;
    logic [7:0] byte_control_mem_sel;
    logic [7:3] addr_data_mux_en;
    logic upper_byte_strobe;
    logic rw_direction;
    logic addr_hold_strobe;
    logic porta7_out;
  } bus_ctl_t;

  typedef struct packed {
    logic chip_sel7_out_en;
    logic chip_sel6_out_en;
    logic chip_sel5_out_en;
    logic chip_sel4_out_en;
    logic [7:4] chip_sel;
  } cs_src_t;

  typedef struct packed {
    logic [1:0] tmr2_compare_out_sel_hi;
    logic [1:0] tmr2_compare_out_sel_lo;
    logic [1:0] tmr3_compare_out_sel_hi;
    logic [1:0] tmr3_compare_out_sel_lo;
    logic tmr2_out;
    logic tmr3_out;
    logic [1:0] dma_ch2_pin_route;
    logic [1:0] dma_ch3_pin_route;
    logic [3:2] dma_single_addr_mode;
    logic [3:2] dma_ack_out_en;
    logic dma_ack_ch2;
    logic dma_ack_ch3;
    logic smart_card_iface;
    logic smartcard_gsm_clock_mode;
    logic tx_on;
    logic rx_on;
    logic [1:0] clock_en_code;
    logic serial_clock_ch4;
  } p6_src_t;

  typedef struct packed {
    logic oe;
    logic out;
  } pin_drv_t;

endpackage

// file: cs_router.sv
// routes chip selects 4..7 onto port b / port f pins by route codes.
// assumes route register and enables come from the same clock domain.
`timescale 1ns/100ps

module cs_router (
  // configuration
  input wire logic [7:0] i_route,
  input wire pin_mux_pkg::cs_src_t i_cs,
  // pin drives: port b 3..0, port f 7..5
  output pin_mux_pkg::pin_drv_t o_pb [3:0],
  output pin_mux_pkg::pin_drv_t o_pf [7:5]
);
  import pin_mux_pkg::*;

  logic [1:0] r7;
  logic [1:0] r6;
  logic [1:0] r5;
  logic [1:0] r4;
  assign r7 = {i_route[CS7_ROUTE_HI_POS], i_route[CS7_ROUTE_LO_POS]};
  assign r6 = {i_route[CS6_ROUTE_HI_POS], i_route[CS6_ROUTE_LO_POS]};
  assign r5 = {i_route[CS5_ROUTE_HI_POS], i_route[CS5_ROUTE_LO_POS]};
  assign r4 = {i_route[CS4_ROUTE_HI_POS], i_route[CS4_ROUTE_LO_POS]};

  function automatic logic sel(input logic en, input logic [1:0] r,
                               input logic [1:0] code);
    sel = en && (r == code);
  endfunction

  // lower-numbered chip select wins a shared pin; assignments run
  // from cs7 down so the later, lower-numbered one overrides
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_pb[i] = '0;
    end
    for (int i = 5; i < 8; i++) begin
      o_pf[i] = '0;
    end
    if (sel(i_cs.chip_sel7_out_en, r7, ROUTE_A)) begin // RULE4
      o_pb[3] = '{1'b1, i_cs.chip_sel[7]};
    end
    if (sel(i_cs.chip_sel7_out_en, r7, ROUTE_B)) begin // RULE4
      o_pb[1] = '{1'b1, i_cs.chip_sel[7]};
    end
    if (sel(i_cs.chip_sel7_out_en, r7, ROUTE_C)) begin // RULE4
      o_pf[7] = '{1'b1, i_cs.chip_sel[7]};
    end
    if (sel(i_cs.chip_sel6_out_en, r6, ROUTE_A)) begin // RULE5
      o_pb[2] = '{1'b1, i_cs.chip_sel[6]};
    end
    if (sel(i_cs.chip_sel6_out_en, r6, ROUTE_B)) begin // RULE5 RULE17
      o_pb[1] = '{1'b1, i_cs.chip_sel[6]};
    end
    if (sel(i_cs.chip_sel6_out_en, r6, ROUTE_C)) begin // RULE5 RULE17
      o_pf[7] = '{1'b1, i_cs.chip_sel[6]};
    end
    if (sel(i_cs.chip_sel6_out_en, r6, ROUTE_D)) begin // RULE5
      o_pf[6] = '{1'b1, i_cs.chip_sel[6]};
    end
    if (sel(i_cs.chip_sel5_out_en, r5, ROUTE_A)) begin // RULE6 RULE17
      o_pb[1] = '{1'b1, i_cs.chip_sel[5]};
    end
    if (sel(i_cs.chip_sel5_out_en, r5, ROUTE_B)) begin // RULE6
      o_pb[0] = '{1'b1, i_cs.chip_sel[5]};
    end
    if (sel(i_cs.chip_sel5_out_en, r5, ROUTE_C)) begin // RULE6 RULE17
      o_pf[7] = '{1'b1, i_cs.chip_sel[5]};
    end
    if (sel(i_cs.chip_sel5_out_en, r5, ROUTE_D)) begin // RULE6
      o_pf[5] = '{1'b1, i_cs.chip_sel[5]};
    end
    if (sel(i_cs.chip_sel4_out_en, r4, ROUTE_A)) begin // RULE7 RULE17
      o_pb[0] = '{1'b1, i_cs.chip_sel[4]};
    end
  end

endmodule

// file: port6_mux.sv
// port 6 output selection: timer compare outputs, dma acknowledges and
// the channel 4 serial clock. purely combinational.
`timescale 1ns/100ps

module port6_mux (
  // peripheral state
  input wire pin_mux_pkg::p6_src_t i_src,
  // pin drives for port 6 bits 5, 2 (tmr/dack) and the serial clock
  output pin_mux_pkg::pin_drv_t o_p65,
  output pin_mux_pkg::pin_drv_t o_p62
);
  import pin_mux_pkg::*;

  function automatic logic cmp_on(input logic [1:0] hi, input logic [1:0] lo);
    cmp_on = (hi != 2'h0) || (lo != 2'h0);
  endfunction

  function automatic logic dack_on(input logic [1:0] route,
                                   input logic single, input logic en);
    dack_on = (route == ROUTE_B) && single && en;
  endfunction

  logic tmo3_oe;
  logic tmo2_oe;
  logic dma_ack_ch3_oe;
  logic dack2_oe;
  logic serial_clock_ch4_oe;

  assign tmo3_oe = cmp_on(i_src.tmr3_compare_out_sel_hi,
                          i_src.tmr3_compare_out_sel_lo); // RULE12
  assign tmo2_oe = cmp_on(i_src.tmr2_compare_out_sel_hi,
                          i_src.tmr2_compare_out_sel_lo); // RULE12
  assign dma_ack_ch3_oe = dack_on(i_src.dma_ch3_pin_route,
                            i_src.dma_single_addr_mode[3],
                            i_src.dma_ack_out_en[3]); // RULE13
  assign dack2_oe = dack_on(i_src.dma_ch2_pin_route,
                            i_src.dma_single_addr_mode[2],
                            i_src.dma_ack_out_en[2]); // RULE13
  // only the smart-card case drives the clock here
  assign serial_clock_ch4_oe = i_src.smart_card_iface &&
    (i_src.smartcard_gsm_clock_mode ||
     ((i_src.tx_on || i_src.rx_on) &&
      (i_src.clock_en_code == CKE_INT_OUT))); // RULE15

  // dma acknowledge ahead of timer output, then serial clock
  always_comb begin
    o_p65 = '0;
    o_p62 = '0;
    if (dma_ack_ch3_oe) begin
      o_p65 = '{1'b1, i_src.dma_ack_ch3};
    end else if (tmo3_oe) begin
      o_p65 = '{1'b1, i_src.tmr3_out};
    end
    if (dack2_oe) begin
      o_p62 = '{1'b1, i_src.dma_ack_ch2};
    end else if (tmo2_oe) begin
      o_p62 = '{1'b1, i_src.tmr2_out};
    end else if (serial_clock_ch4_oe) begin
      o_p62 = '{1'b1, i_src.serial_clock_ch4};
    end
  end

endmodule

// file: pin_function_select_mux.sv
// top of the pin function select block: axi4-lite register slave,
// port 2 / port a selection, and registered pin drives.
// assumes peripherals and software bits share the 10 mhz clock.
`timescale 1ns/100ps

// Functional notes
// RULE1 - pin p24: timer4 b, else serial clock 1, else pulse out 4
// RULE2 - p24 with no peripheral: port output if direction 1, else input
// RULE3 - p23: timer3 d, else pulse out 3, else port or input
// RULE4 - cs7 route 00 pb3, 01 pb1, 10 pf7; 11 prohibited
// RULE5 - cs6 route 00 pb2, 01 pb1, 10 pf7, 11 pf6
// RULE6 - cs5 route 00 pb1, 01 pb0, 10 pf7, 11 pf5
// RULE7 - cs4 drives pb0 only with route 00 and enable set
// RULE8 - bus clock on pa7 when direction 1 and clock select 0
// RULE9 - bus request on pa0 when release and request enables set
// RULE10 - upper byte strobe on pa4 with high-write enable or byte control
// RULE11 - read/write line on pa1 with its enable or byte control
// RULE12 - timer compare out driven when any select field nonzero
// RULE13 - dma ack 2/3 with route 01, single address, ack enabled
// RULE14 - address hold strobe on pa6 when any area 3..7 multiplexed
// RULE15 - smart card: channel 4 clock per tx/rx, cke 01, or gsm mode
// RULE16 - pin enables follow configuration within one clock
// RULE17 - shared chip select pin goes to the lower-numbered select
module pin_function_select_mux (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // axi4-lite write address / data / response
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // peripheral sources
  input wire pin_mux_pkg::port2_src_t i_p2,
  input wire pin_mux_pkg::bus_ctl_t i_bus,
  input wire pin_mux_pkg::cs_src_t i_cs,
  input wire pin_mux_pkg::p6_src_t i_p6,
  // pin drives
  output pin_mux_pkg::pin_drv_t o_p24,
  output pin_mux_pkg::pin_drv_t o_p23,
  output pin_mux_pkg::pin_drv_t o_pa7,
  output pin_mux_pkg::pin_drv_t o_pa6,
  output pin_mux_pkg::pin_drv_t o_pa4,
  output pin_mux_pkg::pin_drv_t o_pa1,
  output pin_mux_pkg::pin_drv_t o_pa0,
  output pin_mux_pkg::pin_drv_t o_pb [3:0],
  output pin_mux_pkg::pin_drv_t o_pf [7:5],
  output pin_mux_pkg::pin_drv_t o_p65,
  output pin_mux_pkg::pin_drv_t o_p62
);
  import pin_mux_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] cs_route_r;
  logic [7:0] port_ctrl_r;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  logic do_write;
  assign do_write = aw_held_r && w_held_r && !o_bvalid;

  // each channel taken once, response after both
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (i_awvalid && o_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= i_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= i_wdata;
      wstrb_r <= i_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
    end else begin
      o_awready <= !(aw_held_r || (i_awvalid && o_awready)) ||
                   (do_write && !(i_awvalid && o_awready));
      o_wready <= !(w_held_r || (i_wvalid && o_wready)) ||
                  (do_write && !(i_wvalid && o_wready));
    end
  end

  // register writes; only byte lane 0 carries data
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_route_r <= CS_ROUTE_RESET;
      port_ctrl_r <= PORT_CTRL_RESET;
    end else if (do_write && wstrb_r[0]) begin
      if (awaddr_r == ADDR_CS_ROUTE) begin
        cs_route_r <= wdata_r[7:0];
      end else if (awaddr_r == ADDR_PORT_CTRL) begin
        port_ctrl_r <= {5'h00, wdata_r[2:0]};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bvalid <= 1'b0;
      o_bresp <= AXI_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      if (awaddr_r == ADDR_CS_ROUTE || awaddr_r == ADDR_PORT_CTRL) begin
        o_bresp <= AXI_OKAY;
      end else begin
        o_bresp <= AXI_SLVERR;
      end
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic [31:0] pin_status;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= AXI_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= AXI_OKAY;
      if (i_araddr == ADDR_CS_ROUTE) begin
        o_rdata <= {24'h000000, cs_route_r};
      end else if (i_araddr == ADDR_PORT_CTRL) begin
        o_rdata <= {24'h000000, port_ctrl_r};
      end else if (i_araddr == ADDR_PIN_STATUS) begin
        o_rdata <= pin_status;
      end else begin
        o_rdata <= 32'h0000_0000;
        o_rresp <= AXI_SLVERR;
      end
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pin selection
  // ----------------------------------------------------------------
  pin_drv_t p24_nxt;
  pin_drv_t p23_nxt;
  pin_drv_t pa7_nxt;
  pin_drv_t pa6_nxt;
  pin_drv_t pa4_nxt;
  pin_drv_t pa1_nxt;
  pin_drv_t pa0_nxt;
  pin_drv_t pb_nxt [3:0];
  pin_drv_t pf_nxt [7:5];
  pin_drv_t p65_nxt;
  pin_drv_t p62_nxt;
  logic byte_ctl;

  assign byte_ctl = |i_bus.byte_control_mem_sel;

  always_comb begin
    p24_nxt = '0;
    if (i_p2.timer4_io_b_oe) begin // RULE1
      p24_nxt = '{1'b1, i_p2.timer4_io_b};
    end else if (i_p2.serial_clock_ch1_oe) begin // RULE1
      p24_nxt = '{1'b1, i_p2.serial_clock_ch1};
    end else if (i_p2.pulse_out_4_oe) begin // RULE1
      p24_nxt = '{1'b1, i_p2.pulse_out_4};
    end else if (port_ctrl_r[PORT24_DIR_POS]) begin // RULE2
      p24_nxt = '{1'b1, i_p2.port24_out};
    end
  end

  always_comb begin
    p23_nxt = '0;
    if (i_p2.timer3_io_d_oe) begin // RULE3
      p23_nxt = '{1'b1, i_p2.timer3_io_d};
    end else if (i_p2.pulse_out_3_oe) begin // RULE3
      p23_nxt = '{1'b1, i_p2.pulse_out_3};
    end else if (port_ctrl_r[PORT23_DIR_POS]) begin // RULE3
      p23_nxt = '{1'b1, i_p2.port23_out};
    end
  end

  always_comb begin
    pa7_nxt = '0;
    pa6_nxt = '0;
    pa4_nxt = '0;
    pa1_nxt = '0;
    pa0_nxt = '0;
    if (port_ctrl_r[PORTA7_DIR_POS]) begin
      if (!i_bus.clock_out_select) begin // RULE8
        pa7_nxt = '{1'b1, i_bus.bus_clock};
      end else begin
        pa7_nxt = '{1'b1, i_bus.porta7_out};
      end
    end
    if (|i_bus.addr_data_mux_en) begin // RULE14
      pa6_nxt = '{1'b1, i_bus.addr_hold_strobe};
    end
    if (i_bus.high_write_strobe_en || byte_ctl) begin // RULE10
      pa4_nxt = '{1'b1, i_bus.upper_byte_strobe};
    end
    if (i_bus.rw_direction_out_en || byte_ctl) begin // RULE11
      pa1_nxt = '{1'b1, i_bus.rw_direction};
    end
    if (i_bus.bus_release_enable && i_bus.bus_request_out_en) begin // RULE9
      pa0_nxt = '{1'b1, i_bus.bus_request_out};
    end
  end

  cs_router u_cs (
    .i_route(cs_route_r),
    .i_cs(i_cs),
    .o_pb(pb_nxt),
    .o_pf(pf_nxt)
  );

  port6_mux u_p6 (
    .i_src(i_p6),
    .o_p65(p65_nxt),
    .o_p62(p62_nxt)
  );

  // ----------------------------------------------------------------
  // output flops: one clock from configuration to pin
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_p24 <= '0;
      o_p23 <= '0;
      o_pa7 <= '0;
      o_pa6 <= '0;
      o_pa4 <= '0;
      o_pa1 <= '0;
      o_pa0 <= '0;
      o_p65 <= '0;
      o_p62 <= '0;
      for (int i = 0; i < 4; i++) begin
        o_pb[i] <= '0;
      end
      for (int i = 5; i < 8; i++) begin
        o_pf[i] <= '0;
      end
    end else begin
      o_p24 <= p24_nxt; // RULE16
      o_p23 <= p23_nxt;
      o_pa7 <= pa7_nxt;
      o_pa6 <= pa6_nxt;
      o_pa4 <= pa4_nxt;
      o_pa1 <= pa1_nxt;
      o_pa0 <= pa0_nxt;
      o_p65 <= p65_nxt;
      o_p62 <= p62_nxt;
      for (int i = 0; i < 4; i++) begin
        o_pb[i] <= pb_nxt[i];
      end
      for (int i = 5; i < 8; i++) begin
        o_pf[i] <= pf_nxt[i];
      end
    end
  end

  // status: which monitored pins are currently driven
  assign pin_status = {21'h000000, o_p62.oe, o_p65.oe, o_pa0.oe,
                       o_pa1.oe, o_pa4.oe, o_pa6.oe, o_pa7.oe,
                       o_p23.oe, o_p24.oe, 2'h0};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  p24_timer_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_p2.timer4_io_b_oe |=> o_p24.oe && o_p24.out == $past(i_p2.timer4_io_b))
    else $error("p24 not timer b"); // RULE1
  p24_input_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_p2.timer4_io_b_oe && !i_p2.serial_clock_ch1_oe && !i_p2.pulse_out_4_oe
    && !port_ctrl_r[PORT24_DIR_POS] |=> !o_p24.oe)
    else $error("p24 driven as input"); // RULE2
  p23_pulse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_p2.timer3_io_d_oe && i_p2.pulse_out_3_oe |=>
    o_p23.oe && o_p23.out == $past(i_p2.pulse_out_3))
    else $error("p23 not pulse out"); // RULE3
  cs7_route_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_cs.chip_sel7_out_en && cs_route_r[7:6] == ROUTE_A |=> o_pb[3].oe)
    else $error("cs7 not on pb3"); // RULE4
  cs4_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !(i_cs.chip_sel4_out_en && cs_route_r[1:0] == ROUTE_A) &&
    !(i_cs.chip_sel5_out_en && cs_route_r[3:2] == ROUTE_B) |=> !o_pb[0].oe)
    else $error("pb0 driven without owner"); // RULE7
  clk_out_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    port_ctrl_r[PORTA7_DIR_POS] && !i_bus.clock_out_select |=>
    o_pa7.oe && o_pa7.out == $past(i_bus.bus_clock))
    else $error("bus clock missing"); // RULE8
  breq_out_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_pa0.oe |-> $past(i_bus.bus_release_enable && i_bus.bus_request_out_en))
    else $error("bus request wrongly driven"); // RULE9
  ahold_out_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_pa6.oe == $past(|i_bus.addr_data_mux_en))
    else $error("addr hold enable wrong"); // RULE14

endmodule

// file: pin_pad_model.sv
// pad model for one port pin: the level the board sees on the wire.
// assumes a weak pull-up on the pad.
`timescale 1ns/100ps

module pin_pad_model (
  // drive from the block
  input wire pin_mux_pkg::pin_drv_t i_drv,
  // wire level
  output logic o_level
);
  // a released pad goes to the pull-up, never holds the last value
  assign o_level = i_drv.oe ? i_drv.out : 1'b1;
endmodule

// file: pin_function_select_mux_tb_top.sv
// testbench for the pin function select block: axi4-lite master,
// peripheral stimulus and pin checks.
// assumes the package and the pad model are compiled first.
`timescale 1ns/100ps

module pin_function_select_mux_tb_top;
  import pin_mux_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int CS_MAP [16] = '{0, 15, 15, 15, 1, 0, 7, 5, 2, 1, 7, 6,
                                 3, 1, 7, 15};
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, lv24;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  port2_src_t p2 = '0;
  bus_ctl_t bus = '0;
  cs_src_t cs = '0;
  p6_src_t p6 = '0;
  pin_drv_t p24, p23, pa7, pa6, pa4, pa1, pa0, p65, p62;
  pin_drv_t pb [3:0];
  pin_drv_t pf [7:5];
  int fails = 0, n_checks = 0, cyc = 0;

  always #50 i_clk = ~i_clk;

  pin_function_select_mux i_pin_function_select_mux (
    .i_clk(i_clk), .i_nrst(i_nrst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready),
    .i_p2(p2), .i_bus(bus), .i_cs(cs), .i_p6(p6),
    .o_p24(p24), .o_p23(p23), .o_pa7(pa7), .o_pa6(pa6), .o_pa4(pa4),
    .o_pa1(pa1), .o_pa0(pa0), .o_pb(pb), .o_pf(pf),
    .o_p65(p65), .o_p62(p62)
  );

  pin_pad_model i_pin_pad_model (.i_drv(p24), .o_level(lv24));

  task automatic end_of_test();
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // the whole run needs under 10000 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  // out is only meaningful while the pin is driven
  task automatic chk_pin(input string nm, input pin_drv_t e,
                         input pin_drv_t g);
    n_checks++;
    if (g.oe !== e.oe || (e.oe && g.out !== e.out)) begin
      fails++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'hF, r);
    chk("bresp", 32'(AXI_OKAY), 32'(r));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(ADDR_CS_ROUTE, d, r);
    chk("route reset", 32'(CS_ROUTE_RESET), d);
    axi_rd(ADDR_PIN_STATUS, d, r);
    chk("status reset", 32'h0, d);
    chk_pin("p24 reset", '0, p24);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(8'h0C, 32'h1, 4'hF, r);
    chk("bresp unmapped", 32'(AXI_SLVERR), 32'(r));
    axi_rd(8'h0C, d, r);
    chk("rresp unmapped", 32'(AXI_SLVERR), 32'(r));
    chk("rdata unmapped", 32'h0, d);
    axi_wr(ADDR_CS_ROUTE, 32'h5A, 4'h0, r);
    axi_rd(ADDR_CS_ROUTE, d, r);
    chk("route no strobe", 32'h0, d);
    wr(ADDR_CS_ROUTE, 32'hFFFFFFA5);
    axi_rd(ADDR_CS_ROUTE, d, r);
    chk("route rw", 32'hA5, d);
    wr(ADDR_PORT_CTRL, 32'hFF);
    axi_rd(ADDR_PORT_CTRL, d, r);
    chk("port ctrl", 32'h7, d);
    axi_rd(ADDR_PIN_STATUS, d, r);
    chk("status driven", 32'h1C, d);
  endtask

  task automatic t_p2();
    logic [4:0] i;
    pin_drv_t e4, e3;
    for (int d = 0; d < 2; d++) begin
      wr(ADDR_PORT_CTRL, d ? 32'h3 : 32'h0);
      for (int k = 0; k < 32; k++) begin
        i = 5'(k);
        @(posedge i_clk);
        p2 <= {i[0], i[3], i[1], ~i[3], i[2], i[4], i[1], i[3], i[2],
               i[4], ~i[4], ~i[3]};
        @(posedge i_clk);
        #1;
        e4.oe = |i[2:0] | d[0];
        e4.out = i[0] ? i[3] : i[1] ? ~i[3] : i[2] ? i[4] : ~i[4];
        e3.oe = i[1] | i[2] | d[0];
        e3.out = i[1] ? i[3] : i[2] ? i[4] : ~i[3];
        chk_pin("p24", e4, p24);
        chk_pin("p23", e3, p23);
        chk("p24 pad", 32'(e4.oe ? e4.out : 1'b1), 32'(lv24));
      end
    end
  endtask

  // later writes overwrite earlier ones, so the lowest select wins
  function automatic pin_drv_t cs_exp(int pin, logic [7:0] rt);
    pin_drv_t e;
    e = '0;
    for (int n = 7; n >= 4; n--) begin
      if (cs[n] && CS_MAP[(n - 4) * 4 + rt[(n - 4) * 2 +: 2]] == pin) begin
        e.oe = 1'b1;
        e.out = cs[n - 4];
      end
    end
    return e;
  endfunction

  task automatic chk_cs(input logic [7:0] rt);
    wr(ADDR_CS_ROUTE, {24'h0, rt});
    @(posedge i_clk);
    #1;
    for (int b = 0; b < 4; b++) begin
      chk_pin("pb", cs_exp(b, rt), pb[b]);
    end
    for (int f = 5; f < 8; f++) begin
      chk_pin("pf", cs_exp(f, rt), pf[f]);
    end
  endtask

  task automatic t_cs();
    for (int k = 0; k < 64; k++) begin
      @(posedge i_clk);
      cs <= {(k[4] ? 4'h1 << k[1:0] : 4'h0), (k[5] ? 4'hA : 4'h5)};
      chk_cs(8'(k[3:2]) << (2 * k[1:0]));
    end
    @(posedge i_clk);
    cs <= 8'hF5;
    chk_cs(8'h55);
    chk_cs(8'hA8);
    chk_cs(8'hFF);
  endtask

  task automatic t_bus();
    logic [7:0] i;
    for (int d = 0; d < 2; d++) begin
      wr(ADDR_PORT_CTRL, d ? 32'h4 : 32'h0);
      for (int k = 0; k < 256; k++) begin
        i = 8'(k);
        @(posedge i_clk);
        bus <= {i[0], i[1], i[2], i[3], ~i[0], i[6], i[7],
                (i[4] ? 8'h01 << i[7:5] : 8'h00),
                (i[5] ? 5'h10 >> i[7:6] : 5'h00),
                i[1] ^ i[2], ~i[3], i[0] ^ i[4], ~i[1]};
        @(posedge i_clk);
        #1;
        chk_pin("pa7", {d[0], i[0] ? ~i[1] : i[1]}, pa7);
        chk_pin("pa0", {i[2] & i[3], ~i[0]}, pa0);
        chk_pin("pa4", {i[6] | i[4], i[1] ^ i[2]}, pa4);
        chk_pin("pa1", {i[7] | i[4], ~i[3]}, pa1);
        chk_pin("pa6", {i[5], i[0] ^ i[4]}, pa6);
      end
    end
  endtask

  task automatic t_p6();
    logic [10:0] i;
    logic a2, a3, t, s;
    for (int k = 0; k < 2048; k++) begin
      i = 11'(k);
      @(posedge i_clk);
      p6 <= {i[7:6], 2'h0, 2'h0, i[7:6], i[1], ~i[2], i[1:0], i[3:2],
             {2{i[4]}}, {2{i[5]}}, i[0], ~i[0], i[8], i[9],
             i[10] & ~i[0], i[10] & i[0], i[1:0] ^ i[3:2], i[3] ^ i[4]};
      @(posedge i_clk);
      #1;
      a3 = i[3:2] == 2'h1 && i[4] && i[5];
      a2 = i[1:0] == 2'h1 && i[4] && i[5];
      t = |i[7:6];
      s = i[8] && (i[9] || (i[10] && (i[1:0] ^ i[3:2]) == 2'h1));
      chk_pin("p65", {a3 | t, a3 ? ~i[0] : ~i[2]}, p65);
      chk_pin("p62", {a2 | t | s, a2 ? i[0] : t ? i[1] : i[3] ^ i[4]},
              p62);
    end
  endtask

  initial begin
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_regs();
    t_p2();
    t_cs();
    t_bus();
    t_p6();
    end_of_test();
  end
endmodule
